// File: gen2_link_option_registers.sv
`timescale 1ns/1ns
`default_nettype none
`include "link_opt_params.svh"
module gen2_link_option_registers (
	input  wire logic                     i_clk,
	input  wire logic                     i_resetn,
	// enable pin, asynchronous to i_clk
	input  wire logic                     i_enable,
	// host register port
	input  wire logic                     i_wr_en,
	input  wire logic                     i_rd_en,
	input  wire link_opt_pkg::reg_addr_t  i_addr,
	input  wire link_opt_pkg::opt_byte_t  i_wdata,
	output logic                          o_rd_valid,
	output logic                          o_addr_hit,
	output link_opt_pkg::opt_byte_t       o_rdata,
	// frame sequencing from the protocol logic
	input  wire logic                     i_frame_start,
	input  wire logic                     i_cmd_strobe,
	input  wire link_opt_pkg::cmd_code_t  i_cmd_code,
	input  wire logic [1:0]               i_rx_coding,
	// decoded settings for transmitter and receiver
	output logic [9:0]                    o_pulse_width_permille,
	output logic [10:0]                   o_one_length_permille,
	output logic                          o_crc5_sel,
	output logic                          o_insert_trcal,
	output logic [1:0]                    o_session,
	output link_opt_pkg::rate_khz_t       o_link_freq_khz,
	output logic                          o_link_freq_valid,
	output logic [7:0]                    o_pilot_periods,
	output logic                          o_long_preamble,
	output logic                          o_preamble_conflict,
	output link_opt_pkg::trcal_t          o_trcal_steps,
	output logic [16:0]                   o_trcal_cycles,
	output logic                          o_gain_increase,
	output logic [2:0]                    o_misc_bits
);
	import link_opt_pkg::*;

	localparam logic [4:0] CAL_STEP = 5'(`CAL_STEP_CYCLES);

	opt_byte_t tx_link_options_r;
	opt_byte_t rx_link_options_r;
	opt_byte_t calibration_period_low_r;
	opt_byte_t calibration_high_misc_r;

	opt_byte_t tx_active;
	opt_byte_t rx_active;
	opt_byte_t cal_low_active;
	opt_byte_t cal_high_active;

	logic      enable_sync;
	logic      preset;

	logic      hit_tx;
	logic      hit_rx;
	logic      hit_cal_low;
	logic      hit_cal_high;
	logic      hit_any;
	opt_byte_t read_mux;

	logic      pulse_width_sel_hi;
	logic      pulse_width_sel_lo;
	logic      one_length_sel_hi;
	logic      one_length_sel_lo;
	logic      crc_type;
	logic      force_calibration_insert;
	logic      session_bit_hi;
	logic      session_bit_lo;
	logic [3:0] backscatter_rate_sel;
	logic [1:0] pilot_interval_shorten;
	logic      preamble_long;
	trcal_t    trcal_value;
	logic      gain_direction;

	logic [9:0]  pw_nxt;
	logic [10:0] one_nxt;
	rate_khz_t   rate_nxt;
	logic        rate_valid_nxt;
	logic [7:0]  pilot_base;
	logic [7:0]  pilot_nxt;
	logic        conflict_nxt;
	logic [16:0] trcal_cycles_nxt;
	logic        cmd_is_query;
	logic        cmd_is_data;
	logic        insert_nxt;

	logic        rd_valid_r;
	logic        addr_hit_r;
	opt_byte_t   rdata_r;
	logic [9:0]  pulse_width_r;
	logic [10:0] one_length_r;
	logic        crc5_r;
	logic        insert_trcal_r;
	logic [1:0]  session_r;
	rate_khz_t   link_freq_r;
	logic        link_freq_valid_r;
	logic [7:0]  pilot_periods_r;
	logic        long_preamble_r;
	logic        conflict_r;
	trcal_t      trcal_steps_r;
	logic [16:0] trcal_cycles_r;
	logic        gain_increase_r;
	logic [2:0]  misc_r;

	// the enable pin is outside the clock domain
	pin_sync #(
		.RESET_LEVEL (1'b0)
	) u_enable_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_async  (i_enable),
		.o_sync   (enable_sync)
	);

	// no separate power-on path: i_resetn serves as the power-on reset
	// enable low holds the host copies and working copies at their preset values
	assign preset = !enable_sync;

	// address decode for the four byte registers
	assign hit_tx       = (i_addr == `ADDR_TX_LINK_OPTIONS);
	assign hit_rx       = (i_addr == `ADDR_RX_LINK_OPTIONS);
	assign hit_cal_low  = (i_addr == `ADDR_CALIBRATION_LOW);
	assign hit_cal_high = (i_addr == `ADDR_CALIBRATION_HIGH_MISC);
	assign hit_any      = hit_tx | hit_rx | hit_cal_low | hit_cal_high;

	// read selection shows the host copy; other addresses read zero
	assign read_mux = hit_tx       ? tx_link_options_r :
	                  hit_rx       ? rx_link_options_r :
	                  hit_cal_low  ? calibration_period_low_r :
	                  hit_cal_high ? calibration_high_misc_r : 8'h00;

	// host copy: preset on reset or enable low, write on strobe
	// rx bit 0 is masked so the reserved bit always reads back zero
	always_ff @(posedge i_clk) begin
		if (!i_resetn || preset) begin
			tx_link_options_r        <= `RST_TX_LINK_OPTIONS;
			rx_link_options_r        <= `RST_RX_LINK_OPTIONS;
			calibration_period_low_r <= `RST_CALIBRATION_LOW;
			calibration_high_misc_r  <= `RST_CALIBRATION_HIGH_MISC;
		end else if (i_wr_en) begin
			if (hit_tx) begin
				tx_link_options_r <= i_wdata;
			end
			if (hit_rx) begin
				rx_link_options_r <= i_wdata & `RX_OPTIONS_WRITE_MASK;
			end
			if (hit_cal_low) begin
				calibration_period_low_r <= i_wdata;
			end
			if (hit_cal_high) begin
				calibration_high_misc_r <= i_wdata;
			end
		end
	end

	// read answer one cycle after the strobe
	// o_rdata keeps the last answer so a slow host may pick it up later
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			rd_valid_r <= 1'b0;
			addr_hit_r <= 1'b0;
			rdata_r    <= 8'h00;
		end else begin
			rd_valid_r <= i_rd_en;
			addr_hit_r <= (i_rd_en | i_wr_en) & hit_any;
			if (i_rd_en) begin
				rdata_r <= read_mux;
			end
		end
	end

	// working copies, taken at each frame start
	frame_shadow #(
		.WIDTH  (8),
		.PRESET (`RST_TX_LINK_OPTIONS)
	) u_tx_shadow (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_preset (preset),
		.i_load   (i_frame_start),
		.i_value  (tx_link_options_r),
		.o_active (tx_active)
	);

	frame_shadow #(
		.WIDTH  (8),
		.PRESET (`RST_RX_LINK_OPTIONS)
	) u_rx_shadow (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_preset (preset),
		.i_load   (i_frame_start),
		.i_value  (rx_link_options_r),
		.o_active (rx_active)
	);

	frame_shadow #(
		.WIDTH  (8),
		.PRESET (`RST_CALIBRATION_LOW)
	) u_cal_low_shadow (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_preset (preset),
		.i_load   (i_frame_start),
		.i_value  (calibration_period_low_r),
		.o_active (cal_low_active)
	);

	frame_shadow #(
		.WIDTH  (8),
		.PRESET (`RST_CALIBRATION_HIGH_MISC)
	) u_cal_high_shadow (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_preset (preset),
		.i_load   (i_frame_start),
		.i_value  (calibration_high_misc_r),
		.o_active (cal_high_active)
	);

	// field split of the working copies
	// working copies, not host copies, feed every decode below
	assign pulse_width_sel_hi       = tx_active[7];
	assign pulse_width_sel_lo       = tx_active[6];
	assign one_length_sel_hi        = tx_active[5];
	assign one_length_sel_lo        = tx_active[4];
	assign crc_type                 = tx_active[3];
	assign force_calibration_insert = tx_active[2];
	assign session_bit_hi           = tx_active[1];
	assign session_bit_lo           = tx_active[0];
	assign backscatter_rate_sel     = rx_active[7:4];
	assign pilot_interval_shorten   = rx_active[3:2];
	assign preamble_long            = rx_active[1];
	assign trcal_value              = {cal_high_active[3:0], cal_low_active};
	assign gain_direction           = cal_high_active[7];

	// pulse and data-one lengths in thousandths of Tari
	assign pw_nxt = ({pulse_width_sel_hi, pulse_width_sel_lo} == 2'b00) ? 10'h10E :
	                ({pulse_width_sel_hi, pulse_width_sel_lo} == 2'b01) ? 10'h15E :
	                ({pulse_width_sel_hi, pulse_width_sel_lo} == 2'b10) ? 10'h1B8 :
	                                                                      10'h1F4;
	assign one_nxt = ({one_length_sel_hi, one_length_sel_lo} == 2'b00) ? 11'h5DC :
	                 ({one_length_sel_hi, one_length_sel_lo} == 2'b01) ? 11'h67C :
	                 ({one_length_sel_hi, one_length_sel_lo} == 2'b10) ? 11'h726 :
	                                                                     11'h7D0;

	// only five rate codes are defined; the rest report not valid
	assign rate_nxt = (backscatter_rate_sel == 4'h0) ? 10'h028 :
	                  (backscatter_rate_sel == 4'h6) ? 10'h0A0 :
	                  (backscatter_rate_sel == 4'h9) ? 10'h100 :
	                  (backscatter_rate_sel == 4'hC) ? 10'h140 :
	                  (backscatter_rate_sel == 4'hF) ? 10'h280 : 10'h000;
	assign rate_valid_nxt = (rate_nxt != 10'h000);

	// faster links measure from 80 periods, slower from 40, so
	// the two bases together reach the whole 80 down to 5 range
	assign pilot_base = (rate_nxt >= 10'h100) ? `PILOT_BASE_LONG : `PILOT_BASE_SHORT;
	assign pilot_nxt  = pilot_base >> pilot_interval_shorten;

	// short preamble is only meant for Miller 4 and Miller 8
	assign conflict_nxt = !preamble_long && !i_rx_coding[1];

	// calibration duration as clock cycles, 25 per step at 250 MHz
	// both factors are widened first so the product keeps its top bits
	assign trcal_cycles_nxt = 17'(trcal_value) * 17'(CAL_STEP);

	// calibration insertion decision per command
	assign cmd_is_query = (i_cmd_code == `CMD_QUERY);
	assign cmd_is_data  = (i_cmd_code == `CMD_TX_WITH_CRC) ||
	                      (i_cmd_code == `CMD_TX_WITHOUT_CRC);
	assign insert_nxt   = cmd_is_query || (force_calibration_insert && cmd_is_data);

	// registered decoded settings; one cycle behind the working copies
	// registering the decode keeps the compare chains off the outputs
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			pulse_width_r     <= 10'h1F4;
			one_length_r      <= 11'h7D0;
			crc5_r            <= 1'b0;
			session_r         <= 2'b00;
			link_freq_r       <= 10'h0A0;
			link_freq_valid_r <= 1'b1;
			pilot_periods_r   <= `PILOT_BASE_SHORT;
			long_preamble_r   <= 1'b0;
			conflict_r        <= 1'b0;
		end else begin
			pulse_width_r     <= pw_nxt;
			one_length_r      <= one_nxt;
			crc5_r            <= crc_type;
			session_r         <= {session_bit_hi, session_bit_lo};
			link_freq_r       <= rate_nxt;
			link_freq_valid_r <= rate_valid_nxt;
			pilot_periods_r   <= pilot_nxt;
			long_preamble_r   <= preamble_long;
			conflict_r        <= conflict_nxt;
		end
	end

	// calibration and gain settings
	// misc bits pass through untouched; their analog use lives elsewhere
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			trcal_steps_r   <= 12'h035;
			trcal_cycles_r  <= 17'h0052D;
			gain_increase_r <= 1'b0;
			misc_r          <= 3'h0;
		end else begin
			trcal_steps_r   <= trcal_value;
			trcal_cycles_r  <= trcal_cycles_nxt;
			gain_increase_r <= gain_direction;
			misc_r          <= cal_high_active[6:4];
		end
	end

	// insertion flag holds from a command strobe until the next one
	// the force bit used is the one taken at the last frame start
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			insert_trcal_r <= 1'b0;
		end else if (i_cmd_strobe) begin
			insert_trcal_r <= insert_nxt;
		end
	end

	assign o_rd_valid             = rd_valid_r;
	assign o_addr_hit             = addr_hit_r;
	assign o_rdata                = rdata_r;
	assign o_pulse_width_permille = pulse_width_r;
	assign o_one_length_permille  = one_length_r;
	assign o_crc5_sel             = crc5_r;
	assign o_insert_trcal         = insert_trcal_r;
	assign o_session              = session_r;
	assign o_link_freq_khz        = link_freq_r;
	assign o_link_freq_valid      = link_freq_valid_r;
	assign o_pilot_periods        = pilot_periods_r;
	assign o_long_preamble        = long_preamble_r;
	assign o_preamble_conflict    = conflict_r;
	assign o_trcal_steps          = trcal_steps_r;
	assign o_trcal_cycles         = trcal_cycles_r;
	assign o_gain_increase        = gain_increase_r;
	assign o_misc_bits            = misc_r;
endmodule // gen2_link_option_registers
`default_nettype wire

// File: link_opt_params.svh
`ifndef LINK_OPT_PARAMS_SVH
`define LINK_OPT_PARAMS_SVH

// register offsets
`define ADDR_TX_LINK_OPTIONS        5'h02
`define ADDR_RX_LINK_OPTIONS        5'h03
`define ADDR_CALIBRATION_LOW        5'h04
`define ADDR_CALIBRATION_HIGH_MISC  5'h05

// reset values
`define RST_TX_LINK_OPTIONS         8'hF0
`define RST_RX_LINK_OPTIONS         8'h60
`define RST_CALIBRATION_LOW         8'h35
`define RST_CALIBRATION_HIGH_MISC   8'h00

// rx options bit 0 is reserved and reads as zero
`define RX_OPTIONS_WRITE_MASK       8'hFE

// direct command codes
`define CMD_QUERY                   8'h98
`define CMD_TX_WITH_CRC             8'h90
`define CMD_TX_WITHOUT_CRC          8'h91

// timing: calibration step and clock period
`define CAL_STEP_NS                 100
`define CLK_PERIOD_NS               4
`define CAL_STEP_CYCLES             (`CAL_STEP_NS / `CLK_PERIOD_NS)

// pilot base interval in link periods
`define PILOT_BASE_LONG             8'h50
`define PILOT_BASE_SHORT            8'h28

`endif

// File: link_opt_pkg.sv
package link_opt_pkg;
	typedef logic [7:0]  opt_byte_t;
	typedef logic [4:0]  reg_addr_t;
	typedef logic [11:0] trcal_t;
	typedef logic [7:0]  cmd_code_t;
	typedef logic [9:0]  rate_khz_t;
endpackage

// File: pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input  wire logic i_clk,
	input  wire logic i_resetn,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_r;
	logic sync_r;

	// two stages; only the second stage is read by anything
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			meta_r <= RESET_LEVEL;
			sync_r <= RESET_LEVEL;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;
endmodule // pin_sync
`default_nettype wire

// File: frame_shadow.sv
`timescale 1ns/1ns
`default_nettype none
module frame_shadow #(
	parameter int          WIDTH = 8,
	parameter logic [7:0]  PRESET = 8'h00
) (
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	input  wire logic             i_preset,
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_value,
	output logic      [WIDTH-1:0] o_active
);
	logic [WIDTH-1:0] active_r;

	// the working copy only follows the host copy at a frame boundary,
	// so a write in mid-frame never changes a frame already under way
	always_ff @(posedge i_clk) begin
		if (!i_resetn || i_preset) begin
			active_r <= PRESET[WIDTH-1:0];
		end else if (i_load) begin
			active_r <= i_value;
		end
	end

	assign o_active = active_r;
endmodule // frame_shadow
`default_nettype wire

// File: link_opt_checker_sva.sv
`timescale 1ns/1ns
`default_nettype none
module link_opt_checker (
	input wire logic                    i_clk,
	input wire logic                    i_resetn,
	input wire logic                    i_enable,
	input wire logic                    i_wr_en,
	input wire logic                    i_rd_en,
	input wire link_opt_pkg::reg_addr_t i_addr,
	input wire logic                    i_frame_start,
	input wire logic                    i_cmd_strobe,
	input wire link_opt_pkg::cmd_code_t i_cmd_code,
	input wire logic [1:0]              i_rx_coding,
	input wire logic                    o_rd_valid,
	input wire logic                    o_addr_hit,
	input wire logic [9:0]              o_pulse_width_permille,
	input wire logic [10:0]             o_one_length_permille,
	input wire logic                    o_insert_trcal,
	input wire link_opt_pkg::rate_khz_t o_link_freq_khz,
	input wire logic                    o_link_freq_valid,
	input wire logic                    o_long_preamble,
	input wire logic                    o_preamble_conflict,
	input wire link_opt_pkg::trcal_t    o_trcal_steps,
	input wire logic [16:0]             o_trcal_cycles
);
	import link_opt_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	// register port answers exactly one cycle after each read strobe; writes to 5'h02 are flagged one cycle later
	read_answer_a: assert property (i_rd_en |=> o_rd_valid)
		else $error("read strobe not answered");
	write_hit_a: assert property (i_wr_en && i_addr == 5'h02 |=> o_addr_hit)
		else $error("mapped write not flagged");
	unmapped_hit_a: assert property ((i_wr_en || i_rd_en) && i_addr > 5'h05 |=> !o_addr_hit)
		else $error("unmapped access flagged");
	// insertion decision follows the command code one cycle later
	query_insert_a: assert property (i_cmd_strobe && i_cmd_code == 8'h98 |=> o_insert_trcal)
		else $error("query without calibration period");
	plain_cmd_a: assert property (i_cmd_strobe && !(i_cmd_code inside {8'h90, 8'h91, 8'h98}) |=> !o_insert_trcal)
		else $error("calibration period on other command");
	rate_valid_a: assert property (o_link_freq_valid == (o_link_freq_khz != 10'h000))
		else $error("rate valid disagrees with rate");
	trcal_scale_a: assert property (o_trcal_cycles == o_trcal_steps * 17'h00019)
		else $error("calibration cycles not steps times 25");
	preamble_ok_a: assert property ($past(i_resetn) |->
		o_preamble_conflict == (!o_long_preamble && !$past(i_rx_coding[1])))
		else $error("preamble conflict flag wrong");
	// enable-low presets are excluded: only a frame start may move the pulse-width decode
	frame_apply_a: assert property (disable iff (!i_resetn || !i_enable)
		$changed(o_pulse_width_permille) |-> $past(i_frame_start, 2))
		else $error("decode moved without frame start");
	tx_preset_a: assert property (disable iff (1'b0)
		!i_resetn |=> o_pulse_width_permille == 10'h1F4 && o_one_length_permille == 11'h7D0)
		else $error("tx preset wrong");
	cal_preset_a: assert property (disable iff (1'b0) !i_resetn |=> o_trcal_steps == 12'h035)
		else $error("calibration preset wrong");
endmodule // link_opt_checker

bind gen2_link_option_registers link_opt_checker link_opt_checker_i (.i_clk, .i_resetn, .i_enable, .i_wr_en,
	.i_rd_en, .i_addr, .i_frame_start, .i_cmd_strobe, .i_cmd_code, .i_rx_coding, .o_rd_valid, .o_addr_hit,
	.o_pulse_width_permille, .o_one_length_permille, .o_insert_trcal, .o_link_freq_khz, .o_link_freq_valid,
	.o_long_preamble, .o_preamble_conflict, .o_trcal_steps, .o_trcal_cycles);
`default_nettype wire

// File: host_port_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
	input  wire logic                    i_clk,
	input  wire logic                    i_rd_valid,
	input  wire link_opt_pkg::opt_byte_t i_rdata,
	output logic                         o_wr_en,
	output logic                         o_rd_en,
	output link_opt_pkg::reg_addr_t      o_addr,
	output link_opt_pkg::opt_byte_t      o_wdata
);
	import link_opt_pkg::*;
	// idle from time zero so no stray strobe reaches the port
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 5'h00;
		o_wdata = 8'h00;
	end
	// one strobe cycle; data inverted after release so stale data never looks valid
	task automatic write_reg(input reg_addr_t a, input opt_byte_t d);
		@(posedge i_clk);
		o_wr_en <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr_en <= 1'b0;
		o_wdata <= ~d;
	endtask
	// bounded wait for the answer; a silent port returns unknown data
	task automatic read_reg(input reg_addr_t a, output opt_byte_t d);
		d = 8'hXX;
		@(posedge i_clk);
		o_rd_en <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd_en <= 1'b0;
		for (int n = 0; n < 4; n++) begin
			#1;
			if (i_rd_valid === 1'b1) begin
				d = i_rdata;
				break;
			end
			@(posedge i_clk);
		end
	endtask
endmodule // host_port_model
`default_nettype wire

// File: gen2_link_option_registers_test.sv
`timescale 1ns/1ns
`default_nettype none
module gen2_link_option_registers_test;
	import link_opt_pkg::*;
	localparam logic [9:0]  PW_TAB [4]   = '{10'h10E, 10'h15E, 10'h1B8, 10'h1F4};
	localparam logic [10:0] ONE_TAB [4]  = '{11'h5DC, 11'h67C, 11'h726, 11'h7D0};
	localparam logic [3:0]  RATE_CODE [6] = '{4'h0, 4'h6, 4'h9, 4'hC, 4'hF, 4'h1};
	localparam logic [9:0]  RATE_KHZ [6] = '{10'h028, 10'h0A0, 10'h100, 10'h140, 10'h280, 10'h000};
	localparam logic [7:0]  CMD_TAB [4]  = '{8'h98, 8'h90, 8'h91, 8'h00};
	logic        clk = 1'b0, resetn = 1'b0, enable = 1'b1, frame_start = 1'b0, cmd_strobe = 1'b0;
	logic [1:0]  rx_coding = 2'h0, session;
	cmd_code_t   cmd_code = 8'h00;
	logic        wr_en, rd_en, rd_valid, addr_hit, crc5, insert, link_valid, long_pre, conflict, gain_inc;
	reg_addr_t   addr;
	opt_byte_t   wdata, rdata;
	logic [9:0]  pw;
	logic [10:0] one;
	rate_khz_t   link_khz;
	logic [7:0]  pilot;
	trcal_t      trcal_steps;
	logic [16:0] trcal_cycles;
	logic [2:0]  misc;
	int          mismatches = 0, total_checks = 0, cycles = 0;

	always #2 clk = ~clk;

	host_port_model host_port_model_i (.i_clk(clk), .i_rd_valid(rd_valid), .i_rdata(rdata), .o_wr_en(wr_en),
		.o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
	gen2_link_option_registers gen2_link_option_registers_i (.i_clk(clk), .i_resetn(resetn), .i_enable(enable),
		.i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rd_valid(rd_valid),
		.o_addr_hit(addr_hit), .o_rdata(rdata), .i_frame_start(frame_start), .i_cmd_strobe(cmd_strobe),
		.i_cmd_code(cmd_code), .i_rx_coding(rx_coding), .o_pulse_width_permille(pw), .o_one_length_permille(one),
		.o_crc5_sel(crc5), .o_insert_trcal(insert), .o_session(session), .o_link_freq_khz(link_khz),
		.o_link_freq_valid(link_valid), .o_pilot_periods(pilot), .o_long_preamble(long_pre),
		.o_preamble_conflict(conflict), .o_trcal_steps(trcal_steps), .o_trcal_cycles(trcal_cycles),
		.o_gain_increase(gain_inc), .o_misc_bits(misc));

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// a hang counts as a failure instead of stalling the run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic check(input logic [16:0] got, input logic [16:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_check(input reg_addr_t a, input opt_byte_t e);
		opt_byte_t d;
		host_port_model_i.read_reg(a, d);
		check(17'(d), 17'(e));
	endtask
	// decode is visible two edges after the frame-start edge
	task automatic apply_frame();
		@(posedge clk);
		frame_start <= 1'b1;
		@(posedge clk);
		frame_start <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic test_reset();
		rd_check(5'h02, 8'hF0);
		rd_check(5'h03, 8'h60);
		rd_check(5'h04, 8'h35);
		rd_check(5'h05, 8'h00);
		check(17'(link_khz), 17'h000A0);
		check(17'(trcal_steps), 17'h00035);
		$display("done reset");
	endtask
	// every width code; decode must not move before the frame start
	task automatic test_tx();
		for (int k = 0; k < 4; k++) begin
			host_port_model_i.write_reg(5'h02, {k[1:0], k[1:0], k[0], 1'b0, k[1:0]});
			#1;
			check(17'(addr_hit), 17'h1);
			check(17'(pw), 17'(k == 0 ? 10'h1F4 : PW_TAB[k-1]));
			rd_check(5'h02, {k[1:0], k[1:0], k[0], 1'b0, k[1:0]});
			apply_frame();
			check(17'(pw), 17'(PW_TAB[k]));
			check(17'(one), 17'(ONE_TAB[k]));
			check(17'(crc5), 17'(k[0]));
			check(17'(session), 17'(k[1:0]));
		end
		$display("done tx");
	endtask
	// short preamble is also tried with FM0 to provoke the conflict flag
	task automatic test_rx();
		logic [7:0] base;
		for (int i = 0; i < 6; i++) begin
			base = (RATE_KHZ[i] >= 10'h100) ? 8'h50 : 8'h28;
			@(posedge clk);
			rx_coding <= i[1:0];
			host_port_model_i.write_reg(5'h03, {RATE_CODE[i], i[1:0], i[0], 1'b1});
			rd_check(5'h03, {RATE_CODE[i], i[1:0], i[0], 1'b0});
			apply_frame();
			check(17'(link_khz), 17'(RATE_KHZ[i]));
			check(17'(link_valid), 17'(i < 5));
			check(17'(pilot), 17'(base >> i[1:0]));
			check(17'(long_pre), 17'(i[0]));
			check(17'(conflict), 17'(!i[0] && !i[1]));
		end
		$display("done rx");
	endtask
	task automatic test_trcal();
		host_port_model_i.write_reg(5'h04, 8'hFF);
		host_port_model_i.write_reg(5'h05, 8'h8A);
		apply_frame();
		check(17'(trcal_steps), 17'h00AFF);
		check(trcal_cycles, 17'h112E7);
		check(17'({gain_inc, misc}), 17'h8);
		host_port_model_i.write_reg(5'h05, 8'h70);
		host_port_model_i.write_reg(5'h04, 8'h01);
		apply_frame();
		check(trcal_cycles, 17'h00019);
		check(17'({gain_inc, misc}), 17'h7);
		$display("done trcal");
	endtask
	task automatic test_cmd();
		for (int f = 0; f < 2; f++) begin
			host_port_model_i.write_reg(5'h02, {5'h1E, f[0], 2'b00});
			apply_frame();
			for (int c = 0; c < 4; c++) begin
				@(posedge clk);
				cmd_strobe <= 1'b1;
				cmd_code <= CMD_TAB[c];
				@(posedge clk);
				cmd_strobe <= 1'b0;
				#1;
				check(17'(insert), 17'(c == 0 || (f == 1 && c < 3)));
			end
		end
		$display("done cmd");
	endtask
	// unmapped places are not flagged and read as zero
	task automatic test_unmapped();
		host_port_model_i.write_reg(5'h06, 8'h5A);
		#1;
		check(17'(addr_hit), 17'h0);
		rd_check(5'h1F, 8'h00);
		check(17'(addr_hit), 17'h0);
		$display("done unmapped");
	endtask
	task automatic test_enable();
		host_port_model_i.write_reg(5'h02, 8'h0B);
		apply_frame();
		@(posedge clk);
		enable <= 1'b0;
		repeat (4) @(posedge clk);
		host_port_model_i.write_reg(5'h02, 8'h33);
		repeat (4) @(posedge clk);
		#1;
		check(17'({pw, session}), 17'({10'h1F4, 2'b00}));
		rd_check(5'h02, 8'hF0);
		@(posedge clk);
		enable <= 1'b1;
		repeat (3) @(posedge clk);
		rd_check(5'h02, 8'hF0);
		$display("done enable");
	endtask

	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		test_reset();
		test_tx();
		test_rx();
		test_trcal();
		test_cmd();
		test_unmapped();
		test_enable();
		complete_run();
	end
endmodule // gen2_link_option_registers_test
`default_nettype wire
